// >>> design/rrb_builder.sv
// Result record builder: tracks one command and emits its result record
// as a stream of 16-bit words, base part first, then optional parts.
// Assumes command, byte and status strobes come from core-clock logic.
// Operation
// RL1: Every record starts with the four-word base part.
// RL2: Parts of units not enabled are left out.
// RL3: Compression part follows the base part directly.
// RL4: MAC part follows base or compression part.
// RL5: Encryption part comes last.
// RL6: Overflow flag set when output exceeds limit and limit not skipped.
// RL7: Tag echoes session value, bit 11 returned as zero.
// RL8: Tag is undefined for memory read and write commands.
// RL9: Input counter drops per byte taken, 18 bits split high and low.
// RL10: Output counter drops per byte stored; undefined for memory commands.
// RL11: Check byte XORs raw bytes from FF, valid only compression alone.
// RL12: CRC-16 preset FFFF over raw bytes, valid only compression alone.
// RL13: Restart flag reported only in alternate compression mode.
// RL14: Terminator flag reported in primary-mode decompression only.
// RL15: Compression early stop flag reported.
// RL16: MAC mismatch flag reported on decode.
// RL17: MAC early stop flag reported.
// RL18: Digest present only when emit digest set; length by options.
// RL19: Digest is 0, 6, 8 or 10 words.
// RL20: Encryption early stop flag reported.
// RL21: Reserved bits in every word are written as zero.
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
module rrb_builder
  import rrb_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Command tracking
  input  wire logic             cmd_start_i,
  input  wire rrb_cmd_t         cmd_i,
  input  wire logic             src_take_i,
  input  wire logic             dst_put_i,
  input  wire logic             raw_valid_i,
  input  wire logic [7:0]       raw_byte_i,
  input  wire logic             cmd_end_i,
  input  wire rrb_stat_t        stat_i,
  input  wire logic [159:0]     digest_i,
  // Record stream
  output logic                  rec_valid_o,
  input  wire logic             rec_ready_i,
  output logic      [15:0]      rec_data_o,
  output logic                  rec_last_o,
  output logic                  busy_o
);

  rrb_state_t   state_r;
  rrb_cmd_t     cmd_r;
  rrb_stat_t    stat_r;
  logic [159:0] dig_r;
  logic [17:0]  in_cnt_r;
  logic [17:0]  out_cnt_r;
  logic         ovf_r;
  logic [7:0]   chkb_r;
  logic [15:0]  crc_r;
  logic [4:0]   idx_r;
  logic [15:0]  data_r;
  logic         valid_r;
  logic [31:0]  ctrl_r;
  logic [31:0]  count_r;
  logic [4:0]   last_len_r;
  logic         ack_r;
  logic [31:0]  rdat_r;

  logic         accept;
  logic         running;
  logic         fire;
  logic         solo;
  logic [4:0]   dig_len;
  logic [4:0]   mac_off;
  logic [4:0]   enc_off;
  logic [4:0]   rec_len;
  logic [4:0]   load_idx;
  logic [15:0]  word_nxt;

  // Raw-data CRC step, MSB first
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction : crc_step

  assign accept  = (state_r == ST_IDLE) && cmd_start_i && ctrl_r[CTRL_EN_BIT];
  assign running = (state_r == ST_RUN);
  assign fire    = valid_r && rec_ready_i;
  assign solo    = cmd_r.en_comp && !cmd_r.en_mac && !cmd_r.en_enc
                   && !cmd_r.en_pad;

  // Part placement and record length
  always_comb begin
    if (!cmd_r.emit_digest) begin
      dig_len = 5'h00;                                           // RL18
    end else if (cmd_r.shorten_digest) begin
      dig_len = DIG_SHORT;                                       // RL19
    end else if (cmd_r.mac_alg_long) begin
      dig_len = DIG_SH;
    end else begin
      dig_len = DIG_MD;
    end
    mac_off = BASE_WORDS + (cmd_r.en_comp ? PART_WORDS : 5'h00); // RL3
    enc_off = mac_off + (cmd_r.en_mac ? PART_WORDS + dig_len     // RL4
                                      : 5'h00);
    rec_len = enc_off + (cmd_r.en_enc ? PART_WORDS : 5'h00);     // RL5
  end

  // Index of the word loaded next into the output register
  assign load_idx = running ? 5'h00 : 5'(idx_r + 5'h01);

  // Record word selection, unused and reserved positions are zero
  always_comb begin
    word_nxt = 16'h0000;                                         // RL21
    if (load_idx == 5'h00) begin
      word_nxt[OVF_BIT] = ovf_r;                                 // RL1
    end else if (load_idx == 5'h01) begin
      // Session echoed; memory commands carry it unchecked
      word_nxt = {in_cnt_r[17:16], out_cnt_r[17:16], 1'b0,       // RL7
                  cmd_r.session[10:0]};                          // RL8
    end else if (load_idx == 5'h02) begin
      word_nxt = in_cnt_r[15:0];                                 // RL9
    end else if (load_idx == 5'h03) begin
      word_nxt = out_cnt_r[15:0];                                // RL10
    end else if (cmd_r.en_comp && load_idx == BASE_WORDS) begin  // RL2
      word_nxt[15:8] = solo ? chkb_r : 8'h00;                    // RL11
      word_nxt[RESTART_BIT] = cmd_r.alternate_compression_mode   // RL13
                              && stat_r.comp_restart;
      word_nxt[TERM_BIT] = !cmd_r.alternate_compression_mode     // RL14
                           && cmd_r.decompress
                           && !cmd_r.history_refresh_only
                           && stat_r.comp_term;
      word_nxt[EARLY_BIT] = stat_r.comp_early;                   // RL15
    end else if (cmd_r.en_comp && load_idx == BASE_WORDS + 5'h01) begin
      word_nxt = solo ? crc_r : 16'h0000;                        // RL12
    end else if (cmd_r.en_mac && load_idx == mac_off) begin
      word_nxt[MISMATCH_BIT] = cmd_r.mac_decode                  // RL16
                               && stat_r.mac_mismatch;
      word_nxt[EARLY_BIT] = stat_r.mac_early;                    // RL17
    end else if (cmd_r.en_mac && load_idx >= mac_off + PART_WORDS
                 && load_idx < enc_off) begin
      word_nxt = dig_r[5'(load_idx - mac_off - PART_WORDS) * 16 +: 16];
    end else if (cmd_r.en_enc && load_idx == enc_off) begin
      word_nxt[EARLY_BIT] = stat_r.enc_early;                    // RL20
    end
  end

  // Command sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (accept) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cmd_end_i) begin
            state_r <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          if (fire && rec_last_o) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Command and outcome capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_r  <= '0;
      stat_r <= '0;
      dig_r  <= '0;
    end else begin
      if (accept) begin
        cmd_r <= cmd_i;
      end
      if (running && cmd_end_i) begin
        stat_r <= stat_i;
        dig_r  <= digest_i;
      end
    end
  end

  // Byte counters and overflow flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_cnt_r  <= '0;
      out_cnt_r <= '0;
      ovf_r     <= 1'b0;
    end else if (accept) begin
      in_cnt_r  <= cmd_i.src_total;
      out_cnt_r <= cmd_i.dst_limit;
      ovf_r     <= 1'b0;
    end else if (running) begin
      if (src_take_i) begin
        in_cnt_r <= in_cnt_r - 18'h00001;                        // RL9
      end
      if (dst_put_i) begin
        if (out_cnt_r != 18'h00000) begin
          out_cnt_r <= out_cnt_r - 18'h00001;                    // RL10
        end else if (!cmd_r.skip_limit) begin
          ovf_r <= 1'b1;                                         // RL6
        end
      end
    end
  end

  // Check byte and CRC over uncompressed bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chkb_r <= CHKB_INIT;
      crc_r  <= CRC_INIT;
    end else if (accept) begin
      chkb_r <= CHKB_INIT;                                       // RL11
      crc_r  <= CRC_INIT;                                        // RL12
    end else if (running && raw_valid_i) begin
      chkb_r <= chkb_r ^ raw_byte_i;
      crc_r  <= crc_step(crc_r, raw_byte_i);
    end
  end

  // Output word register and stream handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_r   <= 5'h00;
      data_r  <= 16'h0000;
      valid_r <= 1'b0;
    end else if (running && cmd_end_i) begin
      idx_r   <= 5'h00;
      data_r  <= word_nxt;
      valid_r <= 1'b1;
    end else if (fire) begin
      if (rec_last_o) begin
        valid_r <= 1'b0;
      end else begin
        idx_r  <= load_idx;
        data_r <= word_nxt;
      end
    end
  end

  assign rec_valid_o = valid_r;
  assign rec_data_o  = data_r;
  assign rec_last_o  = valid_r && (idx_r == 5'(rec_len - 5'h01));
  assign busy_o      = (state_r != ST_IDLE);

  // Completed record statistics
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r    <= 32'h0000_0000;
      last_len_r <= 5'h00;
    end else if (fire && rec_last_o) begin
      count_r    <= count_r + 32'h0000_0001;
      last_len_r <= rec_len;
    end
  end

  // Wishbone slave: one wait state, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
      ctrl_r <= CTRL_RST;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      if (wb_cyc_i && wb_stb_i && !ack_r) begin
        if (wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
          ctrl_r <= {31'h0000_0000, wb_dat_i[CTRL_EN_BIT]};
        end
        case (wb_adr_i)
          REG_CTRL:   rdat_r <= ctrl_r;
          REG_STATUS: rdat_r <= {15'h0000, ovf_r, 3'h0, last_len_r,
                                 6'h00, state_r};
          REG_COUNT:  rdat_r <= count_r;
          default:    rdat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = ack_r ? rdat_r : 32'h0000_0000;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_base_first;
    running && cmd_end_i |=> rec_valid_o && idx_r == 5'h00
      && rec_len >= 5'h04;
  endproperty
  a_base_first: assert property (p_base_first)          // RL1
    else $error("record did not open with base part");

  property p_len;
    rec_valid_o |-> rec_len == 5'h04
      + (cmd_r.en_comp ? 5'h02 : 5'h00)
      + (cmd_r.en_enc ? 5'h02 : 5'h00)
      + (cmd_r.en_mac ? 5'h02 + (!cmd_r.emit_digest ? 5'h00
         : cmd_r.shorten_digest ? 5'h06
         : cmd_r.mac_alg_long ? 5'h0A : 5'h08) : 5'h00);
  endproperty
  a_len: assert property (p_len)                        // RL2
    else $error("record length wrong for enabled units");

  property p_overrun;
    running && dst_put_i && out_cnt_r == 18'h00000
      && !cmd_r.skip_limit |=> ovf_r;
  endproperty
  a_overrun: assert property (p_overrun)                // RL6
    else $error("overflow flag not set");

  property p_tag;
    rec_valid_o && idx_r == 5'h01 |-> !rec_data_o[TAG_DROP_BIT]
      && rec_data_o[10:0] == cmd_r.session[10:0];
  endproperty
  a_tag: assert property (p_tag)                        // RL7
    else $error("session echo wrong");

  property p_src_dec;
    running && src_take_i && !cmd_end_i |=>
      in_cnt_r == $past(in_cnt_r) - 18'h00001;
  endproperty
  a_src_dec: assert property (p_src_dec)                // RL9
    else $error("input counter did not decrement");

  property p_init;
    accept |=> chkb_r == 8'hFF && crc_r == 16'hFFFF;
  endproperty
  a_init: assert property (p_init)                      // RL11
    else $error("check values not preset");

  property p_restart;
    rec_valid_o && cmd_r.en_comp && idx_r == 5'h04
      && !cmd_r.alternate_compression_mode |-> !rec_data_o[RESTART_BIT];
  endproperty
  a_restart: assert property (p_restart)                // RL13
    else $error("restart flag outside alternate mode");

  property p_enc_last;
    rec_valid_o && cmd_r.en_enc && idx_r == 5'(rec_len - 5'h02)
      |-> rec_data_o == {15'h0000, stat_r.enc_early};
  endproperty
  a_enc_last: assert property (p_enc_last)              // RL5
    else $error("encryption part not last");

  property p_reserved;
    rec_valid_o && idx_r == 5'h00 |-> rec_data_o[14:0] == 15'h0000;
  endproperty
  a_reserved: assert property (p_reserved)              // RL21
    else $error("reserved bits not zero");

endmodule : rrb_builder

// >>> design/rrb_pkg.sv
// Package for the result record builder: constants, bit positions, carriers.
// Assumes a single core clock and a classic Wishbone register bus.
package rrb_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_COUNT     = 8'h08;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0001;
  localparam int          CTRL_EN_BIT   = 0;

  // Record geometry in 16-bit words
  localparam logic [4:0]  BASE_WORDS    = 5'h04;
  localparam logic [4:0]  PART_WORDS    = 5'h02;
  localparam logic [4:0]  DIG_SHORT     = 5'h06;
  localparam logic [4:0]  DIG_MD        = 5'h08;
  localparam logic [4:0]  DIG_SH        = 5'h0A;
  localparam int          DIG_MAX       = 10;

  // Field positions inside result words
  localparam int          OVF_BIT       = 15;
  localparam int          TAG_DROP_BIT  = 11;
  localparam int          RESTART_BIT   = 2;
  localparam int          TERM_BIT      = 1;
  localparam int          MISMATCH_BIT  = 1;
  localparam int          EARLY_BIT     = 0;

  // Check values and their start points
  localparam logic [7:0]  CHKB_INIT     = 8'hFF;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'h1021;

  // Command fields captured at command start
  typedef struct packed {
    logic        en_comp;
    logic        en_mac;
    logic        en_enc;
    logic        en_pad;
    logic        mem_rd;
    logic        mem_wr;
    logic        skip_limit;
    logic [11:0] session;
    logic [17:0] src_total;
    logic [17:0] dst_limit;
    logic        alternate_compression_mode;
    logic        decompress;
    logic        history_refresh_only;
    logic        mac_decode;
    logic        mac_alg_long;
    logic        shorten_digest;
    logic        emit_digest;
  } rrb_cmd_t;

  // Unit outcomes reported at command end
  typedef struct packed {
    logic comp_early;
    logic comp_restart;
    logic comp_term;
    logic mac_mismatch;
    logic mac_early;
    logic enc_early;
  } rrb_stat_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_EMIT} rrb_state_t;

endpackage : rrb_pkg

// >>> sim/rrb_sink.sv
// Record sink model: takes result words and logs them with their last flag.
// Assumes the builder holds valid and data steady until a word is taken.
`timescale 1ns/1ps
module rrb_sink (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Bench control
  input  wire logic        stall_i,
  // Record stream
  input  wire logic        rec_valid_i,
  input  wire logic [15:0] rec_data_i,
  input  wire logic        rec_last_i,
  output logic             rec_ready_o
);
  logic [16:0] got[$];  // Logged as last flag and word

  // Ready toggles every cycle while stalling, so holds are exercised
  always @(posedge clk_i) begin
    if (rst_i) begin
      rec_ready_o <= 1'b0;
    end else begin
      rec_ready_o <= stall_i ? ~rec_ready_o : 1'b1;
      if (rec_valid_i && rec_ready_o) got.push_back({rec_last_i, rec_data_i});
    end
  end
endmodule : rrb_sink

// >>> sim/rrb_builder_tb.sv
// Testbench for the result record builder: commands in, records checked.
// Assumes a classic Wishbone master and the record sink model.
`timescale 1ns/1ps
module rrb_builder_tb;
  import rrb_pkg::*;
  logic         clk_i, rst_i, cyc, stb, we, start, take, put, rv, cend, stall;
  logic [7:0]   adr, rb;
  logic [3:0]   sel, lanes;
  logic [31:0]  dat, wdo, q;
  logic         ack, rvalid, rready, rlast, busy;
  logic [15:0]  rdata;
  logic [159:0] dig;
  rrb_cmd_t     cmd, c;
  rrb_stat_t    st, s;
  logic [16:0]  exq[$];
  int           fails, total_checks, runs;

  // Design and far-side model
  rrb_builder i_rrb_builder (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack), .cmd_start_i(start),
    .cmd_i(cmd), .src_take_i(take), .dst_put_i(put), .raw_valid_i(rv),
    .raw_byte_i(rb), .cmd_end_i(cend), .stat_i(st), .digest_i(dig),
    .rec_valid_o(rvalid), .rec_ready_i(rready), .rec_data_o(rdata),
    .rec_last_o(rlast), .busy_o(busy));
  rrb_sink i_rrb_sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
    .rec_valid_i(rvalid), .rec_data_i(rdata), .rec_last_i(rlast),
    .rec_ready_o(rready));

  // Clock at 20 MHz
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic timeout;
    fails++;
    $display("CHECK FAILED %0t wait ran out", $time);
    report_and_stop();
  endtask : timeout

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    sel <= lanes;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    q = wdo;
    cyc <= 1'b0; stb <= 1'b0;
    if (k == 20) timeout();
    @(posedge clk_i);
  endtask : wb

  // Runs one command and compares its record with one worked out here
  task automatic run(input int nt, input int np);
    logic [17:0] sr, dr;
    logic [15:0] cr;
    logic [7:0]  l, b;
    logic        ov, so;
    int          n, k;
    sr = c.src_total; dr = c.dst_limit; ov = 0; l = CHKB_INIT; cr = CRC_INIT;
    so = c.en_comp & ~c.en_mac & ~c.en_enc & ~c.en_pad;
    i_rrb_sink.got.delete(); exq.delete(); runs++;
    @(posedge clk_i); cmd <= c; start <= 1'b1;
    @(posedge clk_i); start <= 1'b0;
    for (int i = 0; i < nt || i < np; i++) begin
      b = 8'h5A + 8'(i * 37);
      @(posedge clk_i); take <= (i < nt); put <= (i < np); rv <= (i < np);
      rb <= b;
      if (i < nt) sr--;
      if (i < np) begin
        if (dr == 0) ov |= ~c.skip_limit;
        else dr--;
        l ^= b;
        cr ^= {b, 8'h00};
        repeat (8) cr = cr[15] ? ((cr << 1) ^ CRC_POLY) : (cr << 1);
      end
    end
    @(posedge clk_i); take <= 0; put <= 0; rv <= 0; cend <= 1'b1; st <= s;
    @(posedge clk_i); cend <= 1'b0;
    exq.push_back({1'b0, ov, 15'h0});
    exq.push_back({1'b0, sr[17:16], dr[17:16], 1'b0, c.session[10:0]});
    exq.push_back({1'b0, sr[15:0]});
    exq.push_back({1'b0, dr[15:0]});
    if (c.en_comp) begin
      exq.push_back({1'b0, so ? l : 8'h00, 5'h00,
        s.comp_restart & c.alternate_compression_mode,
        s.comp_term & ~c.alternate_compression_mode & c.decompress
          & ~c.history_refresh_only, s.comp_early});
      exq.push_back({1'b0, so ? cr : 16'h0000});
    end
    if (c.en_mac) begin
      exq.push_back({15'h0, s.mac_mismatch & c.mac_decode, s.mac_early});
      exq.push_back(17'h0);
      n = !c.emit_digest ? 0 : c.shorten_digest ? 6 : c.mac_alg_long ? 10 : 8;
      for (k = 0; k < n; k++) exq.push_back({1'b0, 16'hD000 + 16'(k)});
    end
    if (c.en_enc) begin
      exq.push_back({16'h0, s.enc_early});
      exq.push_back(17'h0);
    end
    exq[exq.size() - 1][16] = 1'b1;
    for (k = 0; k < 300 && busy !== 1'b0; k++) @(posedge clk_i);
    if (k == 300) timeout();
    @(posedge clk_i);
    chk(i_rrb_sink.got.size(), exq.size());
    foreach (exq[j]) chk(i_rrb_sink.got[j], exq[j]);
  endtask : run

  task automatic t_regs;
    wb(1'b0, REG_CTRL, 32'h0); chk(q, CTRL_RST);
    lanes = 4'h0;
    wb(1'b1, REG_CTRL, 32'h0);
    lanes = 4'hF;
    wb(1'b0, REG_CTRL, 32'h0); chk(q, CTRL_RST);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 32'h0); chk(q, 32'h0);
  endtask : t_regs

  task automatic t_base;
    c = '0; s = '1; c.session = 12'hFAB;
    c.src_total = 18'h30005; c.dst_limit = 18'h10004;
    run(5, 2);
  endtask : t_base

  task automatic t_comp;
    c = '0; s = '1; c.en_comp = 1'b1; c.decompress = 1'b1; c.session = 12'h123;
    c.src_total = 18'h00006; c.dst_limit = 18'h00008;
    run(6, 8);
    c.history_refresh_only = 1'b1; s.comp_early = 1'b0;
    run(6, 8);
    c.en_pad = 1'b1; c.decompress = 1'b0; c.history_refresh_only = 1'b0;
    run(3, 3);
  endtask : t_comp

  task automatic t_all;
    c = '0; s = '1; stall = 1'b1;
    c.en_comp = 1'b1; c.alternate_compression_mode = 1'b1;
    c.en_mac = 1'b1; c.mac_decode = 1'b1; c.mac_alg_long = 1'b1;
    c.emit_digest = 1'b1; c.en_enc = 1'b1;
    c.src_total = 18'h00004; c.dst_limit = 18'h00002;
    run(4, 4);
  endtask : t_all

  task automatic t_digest;
    c = '0; s = '0; c.en_mac = 1'b1; s.mac_mismatch = 1'b1; s.enc_early = 1'b1;
    c.skip_limit = 1'b1; c.dst_limit = 18'h00001;
    run(0, 3);
    c.emit_digest = 1'b1; c.shorten_digest = 1'b1; c.mac_alg_long = 1'b1;
    run(1, 1);
    c.shorten_digest = 1'b0; c.mac_alg_long = 1'b0; s.mac_early = 1'b1;
    run(2, 0);
    stall = 1'b0;
  endtask : t_digest

  task automatic t_refuse;
    wb(1'b1, REG_CTRL, 32'h0);
    @(posedge clk_i); start <= 1'b1;
    @(posedge clk_i); start <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(busy, 1'b0);
    wb(1'b1, REG_CTRL, CTRL_RST);
    wb(1'b0, REG_COUNT, 32'h0); chk(q, runs);
    wb(1'b0, REG_STATUS, 32'h0); chk(q & 32'h0001_1F03, 32'h0000_0E00);
  endtask : t_refuse

  // Main sequence
  initial begin
    fails = 0; total_checks = 0; runs = 0; rst_i = 1'b1;
    {cyc, stb, we, start, take, put, rv, cend, stall} = '0;
    adr = '0; dat = '0; rb = '0; cmd = '0; st = '0;
    sel = '0; lanes = 4'hF;
    for (int k = 0; k < 10; k++) dig[16*k +: 16] = 16'hD000 + 16'(k);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_base();
    t_comp();
    t_all();
    t_digest();
    t_refuse();
    report_and_stop();
  end
endmodule : rrb_builder_tb
